// *** include/flash_region_lock_bits_pkg.sv ***
// Constants and carriers for the flash region protection and event block.
// Assumes a single 100 MHz system clock and synchronous active-high reset.
package flash_region_lock_bits_pkg;
  localparam int NUM_LOCK_BYTES = 4;
  localparam int LOCK_BITS = 32;
  // Register indices of the four lock bytes, byte 0 holds bits 31:24.
  localparam logic [1:0] LOCK_BYTE0_IDX = 2'h0;
  localparam logic [1:0] LOCK_BYTE3_IDX = 2'h3;
  // Configuration field offsets of the stored lock bytes.
  localparam logic [15:0] CFG_LOCK_LOW_OFS = 16'h0008;
  localparam logic [15:0] CFG_LOCK_HIGH_OFS = 16'h000b;
  // Status register bit positions.
  localparam int STAT_CCF_BIT = 7;
  localparam int STAT_RDCOL_BIT = 6;
  localparam int STAT_VIOL_BIT = 4;
  // Config register bit positions.
  localparam int CFG_COMMAND_COMPLETE_IRQ_EN_BIT = 7;
  localparam int CFG_RDCIE_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Flash size threshold below which each bit covers 1 KB.
  localparam int SMALL_FLASH_KB = 32;
  localparam int SMALL_REGION_KB = 1;
  localparam int BOOT_LOAD_CYCLES = 4;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_BUSY = 3'b100
  } ctl_state_e;

  // A program or erase request from the command sequencer.
  typedef struct packed {
    logic valid;
    logic whole_block;
    logic block_sel;
    logic [19:0] addr;
  } cmd_req_s;

  // A bus register access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [7:0] wdata;
  } reg_acc_s;
endpackage : flash_region_lock_bits_pkg

// *** design/region_map.sv ***
// Maps a flash byte address to its protection region index.
// Assumes the flash size in KB is a power of two or a small multiple of 1 KB.
`timescale 1ns/1ps
module region_map #(
  parameter int FLASH_KB = 256
) (
  input wire logic [19:0] i_addr,
  output logic [4:0] o_region
);
  import flash_region_lock_bits_pkg::*;
  localparam int REGION_BYTES = (FLASH_KB < SMALL_FLASH_KB) ? SMALL_REGION_KB * 1024
                                                          : FLASH_KB * 1024 / LOCK_BITS;
  // Small parts use only the lower bits, so region n of the low end is bit n.
  always_comb begin
    o_region = 5'((int'(i_addr) / REGION_BYTES) % LOCK_BITS);
  end
endmodule : region_map

// *** design/flash_region_lock_bits_events.sv ***
// Region protection vector, status flags and event requests of the flash controller.
// Assumes a command sequencer that presents program and erase requests and reports done.
`timescale 1ns/1ps
module flash_region_lock_bits_events #(
  parameter int FLASH_KB = 256
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_unrestricted_mode,
  input wire logic i_low_power,
  input wire logic i_wait_mode,
  input wire logic i_stop_req,
  input wire flash_region_lock_bits_pkg::reg_acc_s i_lock_acc,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_stat_wdata,
  input wire logic i_stat_wr,
  input wire logic [1:0] i_cfg_byte_idx,
  output logic [15:0] o_cfg_addr,
  input wire logic [7:0] i_cfg_byte,
  input wire flash_region_lock_bits_pkg::cmd_req_s i_cmd,
  input wire logic i_cmd_done,
  output logic o_cmd_start,
  input wire logic i_rd_valid,
  input wire logic i_rd_block,
  output logic [7:0] o_lock_rdata,
  output logic [7:0] o_flash_status_reg,
  output logic [7:0] o_flash_config_reg,
  output logic [31:0] o_region_lock_bits,
  output logic o_stop_ack,
  output logic o_cc_irq,
  output logic o_rdcol_irq
);
  import flash_region_lock_bits_pkg::*;

  ctl_state_e state_ff, nxt_state;
  logic [31:0] lock_ff, nxt_lock;
  logic [1:0] ld_ff, nxt_ld;
  logic busy_blk_ff, nxt_busy_blk;
  logic ccf_ff, nxt_ccf;
  logic viol_ff, nxt_viol;
  logic rdcol_ff, nxt_rdcol;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [4:0] region;
  logic [15:0] blk_mask;
  logic refused, accept, collide;

  // Maps lock register index to its bit position in the vector.
  function automatic int unsigned byte_lsb(input logic [1:0] idx);
    byte_lsb = 8 * (3 - int'(idx));
  endfunction : byte_lsb

  region_map #(.FLASH_KB(FLASH_KB)) u_map (
    .i_addr(i_cmd.addr),
    .o_region(region)
  );

  // Lower half of the regions belongs to block 0, upper half to block 1.
  assign blk_mask = i_cmd.block_sel ? lock_ff[31:16] : lock_ff[15:0];
  assign refused = i_cmd.whole_block ? (blk_mask != 16'hffff) : !lock_ff[region];
  assign accept = (state_ff == ST_IDLE) && i_cmd.valid && !i_low_power && !viol_ff;
  assign collide = (state_ff == ST_BUSY) && i_rd_valid && (i_rd_block == busy_blk_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_lock = lock_ff;
    nxt_ld = ld_ff;
    nxt_busy_blk = busy_blk_ff;
    nxt_ccf = ccf_ff;
    nxt_viol = viol_ff;
    nxt_rdcol = rdcol_ff;
    nxt_cfg = i_cfg_wr ? i_cfg_wdata : cfg_ff;
    // Read data only moves on a read, so a stray index change cannot alter a held byte.
    nxt_rdata = i_lock_acc.rd ? lock_ff[byte_lsb(i_lock_acc.idx) +: 8] : rdata_ff;
    // Status clears are write-one; hardware sets below win over them.
    if (i_stat_wr && i_stat_wdata[STAT_VIOL_BIT]) begin
      nxt_viol = 1'b0;
    end
    if (i_stat_wr && i_stat_wdata[STAT_RDCOL_BIT]) begin
      nxt_rdcol = 1'b0;
    end
    unique case (state_ff)
      ST_LOAD: begin
        nxt_lock[byte_lsb(i_cfg_byte_idx) +: 8] = i_cfg_byte;
        nxt_ld = ld_ff + 2'h1;
        if (ld_ff == LOCK_BYTE3_IDX) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (i_lock_acc.wr) begin
          nxt_lock[byte_lsb(i_lock_acc.idx) +: 8] = i_unrestricted_mode ? i_lock_acc.wdata
              : (lock_ff[byte_lsb(i_lock_acc.idx) +: 8] & i_lock_acc.wdata);
        end
        if (accept) begin
          if (refused) begin
            nxt_viol = 1'b1;
          end else begin
            nxt_state = ST_BUSY;
            nxt_ccf = 1'b0;
            nxt_busy_blk = i_cmd.block_sel;
          end
        end
      end
      ST_BUSY: begin
        if (i_cmd_done) begin
          nxt_state = ST_IDLE;
          nxt_ccf = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (collide) begin
      nxt_rdcol = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff <= ST_LOAD;
      lock_ff <= 32'h0;
      ld_ff <= LOCK_BYTE0_IDX;
      busy_blk_ff <= 1'b0;
      ccf_ff <= 1'b1;
      viol_ff <= 1'b0;
      rdcol_ff <= 1'b0;
      cfg_ff <= CFG_RESET;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      lock_ff <= nxt_lock;
      ld_ff <= nxt_ld;
      busy_blk_ff <= nxt_busy_blk;
      ccf_ff <= nxt_ccf;
      viol_ff <= nxt_viol;
      rdcol_ff <= nxt_rdcol;
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // Index 0 stores bits 31:24, which lives at the highest configuration offset.
  assign o_cfg_addr = CFG_LOCK_HIGH_OFS - 16'(ld_ff);
  assign o_cmd_start = accept && !refused;
  assign o_lock_rdata = rdata_ff;
  assign o_region_lock_bits = lock_ff;
  assign o_flash_config_reg = cfg_ff;
  assign o_flash_status_reg = {ccf_ff, rdcol_ff, 1'b0, viol_ff, 4'h0};
  // stop only after the command ends
  assign o_stop_ack = i_stop_req && (state_ff == ST_IDLE);
  assign o_cc_irq = ccf_ff && cfg_ff[CFG_COMMAND_COMPLETE_IRQ_EN_BIT];
  assign o_rdcol_irq = rdcol_ff && cfg_ff[CFG_RDCIE_BIT];

  a_restrict_no_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == ST_IDLE && i_lock_acc.wr && !i_unrestricted_mode) |=>
      ((lock_ff & ~$past(lock_ff)) == 32'h0)) else $error("lock bit set in restricted mode");
  a_free_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == ST_IDLE && i_lock_acc.wr && i_unrestricted_mode)
      |=> (8'(lock_ff >> byte_lsb($past(i_lock_acc.idx))) == $past(i_lock_acc.wdata)))
    else $error("free write lost");
  a_viol_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (accept && refused) |=> (viol_ff && state_ff == ST_IDLE)) else $error("violation missed");
  a_block_erase: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (accept && i_cmd.whole_block && blk_mask != 16'hffff) |-> !o_cmd_start)
    else $error("locked block erased");
  a_load_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($rose(state_ff == ST_IDLE) && $past(state_ff == ST_LOAD)) |-> $past(ld_ff) == 2'h3)
    else $error("short load");
  a_cc_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == ST_BUSY && i_cmd_done && cfg_ff[CFG_COMMAND_COMPLETE_IRQ_EN_BIT] && !i_cfg_wr) |=> o_cc_irq)
    else $error("complete request missing");
  a_wait_wake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == ST_BUSY && i_cmd_done && i_wait_mode && cfg_ff[CFG_COMMAND_COMPLETE_IRQ_EN_BIT] && !i_cfg_wr)
      |=> (o_cc_irq && state_ff == ST_IDLE)) else $error("no wake from wait");
  a_stop_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == ST_BUSY) |-> !o_stop_ack) else $error("stop granted during command");
  a_vlp_block: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_low_power |-> !o_cmd_start) else $error("command taken in low power");
  a_collision: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    collide |=> rdcol_ff) else $error("collision missed");
  a_no_cross: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == ST_BUSY && i_rd_valid && i_rd_block != busy_blk_ff && !rdcol_ff) |=>
      !rdcol_ff) else $error("false collision");
  a_rdcol_irq: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_rdcol_irq && !(i_stat_wr && i_stat_wdata[STAT_RDCOL_BIT]) && !i_cfg_wr) |=>
      o_rdcol_irq) else $error("collision request dropped");
endmodule : flash_region_lock_bits_events

// *** sim/flash_cfg_model.sv ***
// Model of the configuration field that answers the boot load of the lock bytes.
// Assumes the block shows one field address at a time and takes the byte at once.
`timescale 1ns/1ps
module flash_cfg_model #(
  parameter logic [31:0] STORED = 32'hfff0fffe
) (
  input wire logic [15:0] i_cfg_addr,
  output logic [1:0] o_byte_idx,
  output logic [7:0] o_byte
);
  import flash_region_lock_bits_pkg::*;
  logic [15:0] ofs;
  always_comb begin
    ofs = CFG_LOCK_HIGH_OFS - i_cfg_addr;
    o_byte_idx = ofs[1:0];
    if (i_cfg_addr < CFG_LOCK_LOW_OFS || i_cfg_addr > CFG_LOCK_HIGH_OFS) begin
      // Nothing is held here, so a changing pattern stops a stale byte passing.
      o_byte = ~i_cfg_addr[7:0];
    end else begin
      o_byte = STORED[8*(3-ofs[1:0]) +: 8];
    end
  end
endmodule : flash_cfg_model

// *** sim/flash_region_lock_bits_events_tb_top.sv ***
// Testbench of the lock vector, status flags and event requests.
// Assumes the configuration field model answers the boot load.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module flash_region_lock_bits_events_tb_top;
  import flash_region_lock_bits_pkg::*;
  logic i_clk = 0, rst = 1, unr = 0, lp = 0, wt = 0, stp = 0, cwr = 0, swr = 0;
  logic done = 0, rdv = 0, rdb = 0, start, sack, ccirq, rcirq;
  logic [7:0] cwd = 8'h00, swd = 8'h00, lrd, sts, cfg, cbyte;
  logic [1:0] cidx;
  logic [15:0] caddr;
  logic [31:0] lock;
  reg_acc_s acc = '0;
  cmd_req_s cmd = '0;
  int num_errors = 0, checked = 0, cycles = 0;
  always #5 i_clk = ~i_clk;
  flash_cfg_model u_cfg (.i_cfg_addr(caddr), .o_byte_idx(cidx), .o_byte(cbyte));
  flash_region_lock_bits_events #(.FLASH_KB(256)) uut (.i_clk(i_clk), .i_sys_rst(rst),
    .i_unrestricted_mode(unr), .i_low_power(lp), .i_wait_mode(wt), .i_stop_req(stp),
    .i_lock_acc(acc), .i_cfg_wdata(cwd), .i_cfg_wr(cwr), .i_stat_wdata(swd),
    .i_stat_wr(swr), .i_cfg_byte_idx(cidx), .o_cfg_addr(caddr), .i_cfg_byte(cbyte),
    .i_cmd(cmd), .i_cmd_done(done), .o_cmd_start(start), .i_rd_valid(rdv),
    .i_rd_block(rdb), .o_lock_rdata(lrd), .o_flash_status_reg(sts),
    .o_flash_config_reg(cfg), .o_region_lock_bits(lock), .o_stop_ack(sack),
    .o_cc_irq(ccirq), .o_rdcol_irq(rcirq));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic wr_lock(input logic [1:0] idx, input logic [7:0] v);
    acc = '{wr: 1'b1, rd: 1'b1, idx: idx, wdata: v};
    @(negedge i_clk);
    acc.wr = 1'b0;
    @(negedge i_clk);
  endtask : wr_lock
  task automatic wr_reg(input logic stat, input logic [7:0] v);
    swd = v;
    cwd = v;
    swr = stat;
    cwr = !stat;
    @(negedge i_clk);
    swr = 1'b0;
    cwr = 1'b0;
    @(negedge i_clk);
  endtask : wr_reg
  task automatic issue(input logic whole, input logic [19:0] a, input logic e);
    cmd = '{valid: 1'b1, whole_block: whole, block_sel: 1'b0, addr: a};
    #1 `CHK("start", e, start)
    @(negedge i_clk);
    cmd.valid = 1'b0;
  endtask : issue
  task automatic rd(input logic blk);
    rdb = blk;
    rdv = 1'b1;
    @(negedge i_clk);
    rdv = 1'b0;
    @(negedge i_clk);
  endtask : rd
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 500) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(negedge i_clk);
    rst = 0;
    repeat (6) @(negedge i_clk);
    `CHK("lock", 32'hfff0fffe, lock)
    // lock bytes are written only while no command runs.
    wr_lock(2'h0, 8'h0f);
    `CHK("byte0", 8'h0f, lrd)
    wr_lock(2'h0, 8'hf3);
    `CHK("byte0", 8'h03, lrd)
    unr = 1;
    wr_lock(2'h0, 8'hf3);
    `CHK("lock", 32'hf3f0fffe, lock)
    unr = 0;
    $display("test lock writes done");
    issue(1'b0, 20'h01fff, 1'b0);
    `CHK("status", 8'h90, sts)
    wr_reg(1'b1, 8'h10);
    `CHK("status", 8'h80, sts)
    issue(1'b1, 20'h02000, 1'b0);
    `CHK("status", 8'h90, sts)
    wr_reg(1'b1, 8'h10);
    lp = 1;
    issue(1'b0, 20'h02000, 1'b0);
    lp = 0;
    $display("test refusals done");
    wr_reg(1'b0, 8'hc0);
    `CHK("config", 8'hc0, cfg)
    wt = 1;
    // stop is only requested; it is entered after the grant.
    stp = 1;
    issue(1'b0, 20'h02000, 1'b1);
    `CHK("status", 8'h00, sts)
    `CHK("stop", 1'b0, sack)
    rd(1'b1);
    `CHK("status", 8'h00, sts)
    // the busy block is read on purpose
    rd(1'b0);
    `CHK("status", 8'h40, sts)
    `CHK("rdcol_irq", 1'b1, rcirq)
    done = 1;
    @(negedge i_clk);
    done = 0;
    @(negedge i_clk);
    `CHK("status", 8'hc0, sts)
    `CHK("cc_irq", 1'b1, ccirq)
    `CHK("stop", 1'b1, sack)
    wr_reg(1'b1, 8'h40);
    `CHK("rdcol_irq", 1'b0, rcirq)
    wr_reg(1'b0, 8'h00);
    `CHK("cc_irq", 1'b0, ccirq)
    stp = 0;
    wt = 0;
    $display("test command events done");
    complete_run();
  end
endmodule : flash_region_lock_bits_events_tb_top
